// >>> acsr_top.sv
// status and sampling configuration registers behind a classic wishbone slave
// Notes on behaviour
// - upper count register shows fill count bits 13:8
// - lower count register shows fill count bits 7:0
// - read port returns next buffered byte
// - motion class is a two-bit read-only field
// - engine state message in four low bits
// - bit 5 flags non-unique axis remapping
// - bit 6 flags rate below 50 Hz need
// - bit 7 flags rate below wakeup need
// - sampling config resets to a8, read-write fields
// - rate codes 1..c map to doubling rates
// - rate does not depend on power mode
// - continuous mode bandwidth picks oversampling ratio
// - averaging mode averages two to the n
// - top config bit picks averaging or filter
`timescale 1ns/1ps
`default_nettype none

module acsr_top #(
  parameter logic [3:0] WAKE_MIN_RATE = 4'h8
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [9:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic FIFO_PUSH_I,
  input wire logic [7:0] FIFO_HEAD_I,
  output logic FIFO_POP_O,
  input wire logic [1:0] MOTION_CLASS_I,
  input wire logic [3:0] ENGINE_STATE_I,
  input wire logic SLOW_FEAT_EN_I,
  input wire logic WAKE_EN_I,
  output logic [3:0] RATE_CODE_O,
  output logic [11:0] RATE_STEPS_O,
  output logic RATE_VALID_O,
  output logic PERF_MODE_O,
  output logic [1:0] OVERSAMPLE_O,
  output logic [2:0] AVG_LOG2_O,
  output logic BW_VALID_O,
  output logic [5:0] AXIS_REMAP_O
);

  acsr_pkg::acsr_state_type state_ff;
  acsr_pkg::acsr_state_type nxt_state;
  acsr_pkg::acsr_ovs_type ovs;

  logic [7:0] idx;
  logic req;
  logic count_nz;
  logic consume;
  logic wr_take;
  logic axis_fault;
  logic slow_fault;
  logic wake_fault;
  logic [7:0] health;
  logic [1:0] ax_x;
  logic [1:0] ax_y;
  logic [1:0] ax_z;

  acsr_cfg_decode u_decode (
    .cfg_i(state_ff.cfg),
    .rate_code_o(RATE_CODE_O),
    .rate_steps_o(RATE_STEPS_O),
    .rate_valid_o(RATE_VALID_O),
    .perf_mode_o(PERF_MODE_O),
    .oversample_o(ovs),
    .avg_log2_o(AVG_LOG2_O),
    .bw_valid_o(BW_VALID_O)
  );

  assign OVERSAMPLE_O = ovs;
  assign AXIS_REMAP_O = state_ff.remap;
  assign ACK_O = state_ff.ack;
  assign DAT_O = {24'h000000, state_ff.rdat};

  always_comb begin
    idx = ADR_I[9:2];
    req = CYC_I && STB_I;
    count_nz = (state_ff.count != 14'h0000);
    // the pop happens at the edge where the master takes the answer, so a
    // stalled master never loses a byte
    // only a read taken with data pops, so a push landing after an empty read is kept
    consume = state_ff.ack && req && !WE_I &&
              (idx == acsr_pkg::IDX_FIFO_READ_PORT) && state_ff.pop_due;
    wr_take = state_ff.ack && req && WE_I && SEL_I[0];
    ax_x = state_ff.remap[1:0];
    ax_y = state_ff.remap[3:2];
    ax_z = state_ff.remap[5:4];
    // each target must take a distinct source axis, code 3 names no axis
    axis_fault = (ax_x == ax_y) || (ax_x == ax_z) || (ax_y == ax_z) ||
                 (ax_x == 2'h3) || (ax_y == 2'h3) || (ax_z == 2'h3);
    slow_fault = SLOW_FEAT_EN_I && (RATE_CODE_O < acsr_pkg::RATE_50HZ);
    wake_fault = WAKE_EN_I && (RATE_CODE_O < WAKE_MIN_RATE);
    health = 8'h00;
    health[3:0] = ENGINE_STATE_I;
    health[acsr_pkg::HEALTH_AXIS_FAULT_BIT] = axis_fault;
    health[acsr_pkg::HEALTH_SLOW_FAULT_BIT] = slow_fault;
    health[acsr_pkg::HEALTH_WAKE_FAULT_BIT] = wake_fault;
  end

  assign FIFO_POP_O = consume;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff.phase)
      acsr_pkg::PH_IDLE: begin
        nxt_state.ack = 1'b0;
        nxt_state.pop_due = 1'b0;
        if (req) begin
          nxt_state.phase = acsr_pkg::PH_RESP;
          nxt_state.ack = 1'b1;
          nxt_state.rdat = 8'h00;
          if (!WE_I) begin
            case (idx)
              acsr_pkg::IDX_FIFO_COUNT_LOW: nxt_state.rdat = state_ff.count[7:0];
              acsr_pkg::IDX_FIFO_COUNT_HIGH: begin
                nxt_state.rdat = {2'b00, state_ff.count[13:8]};
              end
              acsr_pkg::IDX_FIFO_READ_PORT: begin
                nxt_state.rdat = count_nz ? FIFO_HEAD_I : 8'h00;
                nxt_state.pop_due = count_nz;
              end
              acsr_pkg::IDX_MOTION_CLASS: nxt_state.rdat = {6'h00, MOTION_CLASS_I};
              acsr_pkg::IDX_ENGINE_HEALTH: nxt_state.rdat = health;
              acsr_pkg::IDX_ACCEL_SAMPLING_CFG: nxt_state.rdat = state_ff.cfg;
              acsr_pkg::IDX_AXIS_REMAP: nxt_state.rdat = {2'b00, state_ff.remap};
              default: nxt_state.rdat = 8'h00;
            endcase
          end
        end
      end
      acsr_pkg::PH_RESP: begin
        // the answer is given once; the master must drop its request
        nxt_state.phase = acsr_pkg::PH_IDLE;
        nxt_state.ack = 1'b0;
        nxt_state.pop_due = 1'b0;
        if (wr_take && (idx == acsr_pkg::IDX_ACCEL_SAMPLING_CFG)) begin
          nxt_state.cfg = DAT_I[7:0];
        end
        if (wr_take && (idx == acsr_pkg::IDX_AXIS_REMAP)) begin
          nxt_state.remap = DAT_I[5:0];
        end
      end
      default: begin
        nxt_state.phase = acsr_pkg::PH_IDLE;
        nxt_state.ack = 1'b0;
        nxt_state.pop_due = 1'b0;
      end
    endcase
    // a push in the same cycle as a pop leaves the count unchanged
    if (FIFO_PUSH_I && !consume && (state_ff.count != 14'h3fff)) begin
      nxt_state.count = state_ff.count + 14'h0001;
    end else if (consume && !FIFO_PUSH_I) begin
      nxt_state.count = state_ff.count - 14'h0001;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_ff.phase <= acsr_pkg::PH_IDLE;
      state_ff.ack <= 1'b0;
      state_ff.pop_due <= 1'b0;
      state_ff.rdat <= acsr_pkg::RST_READ_DATA;
      state_ff.cfg <= acsr_pkg::RST_ACCEL_SAMPLING_CFG;
      state_ff.remap <= acsr_pkg::RST_AXIS_REMAP;
      state_ff.count <= acsr_pkg::RST_FIFO_COUNT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  logic rd_ack;
  assign rd_ack = ACK_O && !WE_I;

  bus_ack_pulse_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");

  bus_ack_follow_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (CYC_I && STB_I && !ACK_O && state_ff.phase == acsr_pkg::PH_IDLE) |=> ACK_O)
    else $error("request not answered in one cycle");

  count_high_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_FIFO_COUNT_HIGH) |->
    (DAT_O == {26'h0, $past(state_ff.count[13:8])}))
    else $error("upper count read wrong");

  count_low_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_FIFO_COUNT_LOW) |->
    (DAT_O[7:0] == $past(state_ff.count[7:0])))
    else $error("lower count read wrong");

  read_port_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_FIFO_READ_PORT && $past(count_nz)) |->
    (DAT_O[7:0] == $past(FIFO_HEAD_I)))
    else $error("read port byte wrong");

  pop_count_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (FIFO_POP_O && !FIFO_PUSH_I) |=> (state_ff.count == $past(state_ff.count) - 14'h0001))
    else $error("pop did not lower count");

  motion_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_MOTION_CLASS) |->
    (DAT_O == {30'h0, $past(MOTION_CLASS_I)}))
    else $error("motion class read wrong");

  health_msg_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_ENGINE_HEALTH) |->
    (DAT_O[3:0] == $past(ENGINE_STATE_I) && DAT_O[4] == 1'b0))
    else $error("engine state read wrong");

  axis_fault_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_ENGINE_HEALTH &&
     $past(AXIS_REMAP_O[1:0]) == $past(AXIS_REMAP_O[3:2])) |-> DAT_O[5])
    else $error("duplicate axis not flagged");

  slow_fault_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_ENGINE_HEALTH) |->
    (DAT_O[6] == ($past(SLOW_FEAT_EN_I) && $past(RATE_CODE_O) < 4'h7)))
    else $error("slow feature fault wrong");

  wake_fault_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_ENGINE_HEALTH && !$past(WAKE_EN_I)) |->
    !DAT_O[7])
    else $error("wake fault without wakeup");

  cfg_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (ACK_O && CYC_I && STB_I && WE_I && SEL_I[0] && idx == acsr_pkg::IDX_ACCEL_SAMPLING_CFG)
    |=> (RATE_CODE_O == $past(DAT_I[3:0]) && PERF_MODE_O == $past(DAT_I[7])))
    else $error("config write lost");

  quad_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (PERF_MODE_O && state_ff.cfg[6:4] == 3'h0) |-> (OVERSAMPLE_O == 2'h2 && AVG_LOG2_O == 3'h0))
    else $error("quad oversample not chosen");

  avg_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    !PERF_MODE_O |-> (AVG_LOG2_O == state_ff.cfg[6:4] && BW_VALID_O))
    else $error("averaging count wrong");

  rate_map_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (RATE_CODE_O == 4'hc) |-> (RATE_STEPS_O == 12'h800 && RATE_VALID_O))
    else $error("top rate code wrong");

  rate_reserved_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (RATE_CODE_O == 4'h0 || RATE_CODE_O > 4'hc) |-> (!RATE_VALID_O && RATE_STEPS_O == 12'h000))
    else $error("reserved rate accepted");

  rate_fifty_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (RATE_CODE_O == 4'h7) |-> (RATE_STEPS_O == 12'h040 && RATE_VALID_O))
    else $error("fifty hertz code wrong");

  dual_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (PERF_MODE_O && state_ff.cfg[6:4] == 3'h1) |-> (OVERSAMPLE_O == 2'h1 && BW_VALID_O))
    else $error("dual oversample not chosen");

  bw_reserved_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (PERF_MODE_O && state_ff.cfg[6:4] > 3'h2) |-> (!BW_VALID_O && OVERSAMPLE_O == 2'h3))
    else $error("reserved bandwidth accepted");

  filter_off_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    !PERF_MODE_O |-> (OVERSAMPLE_O == 2'h3))
    else $error("filter active in averaging mode");

  empty_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_FIFO_READ_PORT && !$past(count_nz)) |->
    (DAT_O == 32'h00000000 && !FIFO_POP_O))
    else $error("empty read port misbehaved");

  push_count_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (FIFO_PUSH_I && !FIFO_POP_O && state_ff.count != 14'h3fff) |=>
    (state_ff.count == $past(state_ff.count) + 14'h0001))
    else $error("push did not raise count");

  wake_fault_set_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_ENGINE_HEALTH && $past(WAKE_EN_I) &&
     $past(RATE_CODE_O) < WAKE_MIN_RATE) |-> DAT_O[7])
    else $error("wake fault not flagged");

  axis_unused_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (rd_ack && $past(idx) == acsr_pkg::IDX_ENGINE_HEALTH &&
     $past(AXIS_REMAP_O[5:4]) == 2'h3) |-> DAT_O[5])
    else $error("unused source axis not flagged");

  sel_gate_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    (ACK_O && CYC_I && STB_I && WE_I && !SEL_I[0]) |=> $stable(state_ff.cfg))
    else $error("write without byte enable took effect");

  pop_only_ack_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    FIFO_POP_O |-> (ACK_O && !WE_I && state_ff.count != 14'h0000))
    else $error("pop outside a read answer");

  pop_cov_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) FIFO_POP_O);
  cfg_cov_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    ACK_O && WE_I && idx == acsr_pkg::IDX_ACCEL_SAMPLING_CFG);
  fault_cov_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    rd_ack && DAT_O[5]);
  push_pop_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    FIFO_POP_O && FIFO_PUSH_I);
  wake_cov_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    rd_ack && DAT_O[7]);

endmodule

`default_nettype wire

// >>> acsr_pkg.sv
// shared constants and types of the acceleration status and configuration registers
package acsr_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_FIFO_COUNT_LOW = 8'h24;
  localparam logic [7:0] IDX_FIFO_COUNT_HIGH = 8'h25;
  localparam logic [7:0] IDX_FIFO_READ_PORT = 8'h26;
  localparam logic [7:0] IDX_MOTION_CLASS = 8'h27;
  localparam logic [7:0] IDX_ENGINE_HEALTH = 8'h2a;
  localparam logic [7:0] IDX_ACCEL_SAMPLING_CFG = 8'h40;
  localparam logic [7:0] IDX_AXIS_REMAP = 8'h58;

  // reset values
  localparam logic [7:0] RST_ACCEL_SAMPLING_CFG = 8'ha8;
  localparam logic [5:0] RST_AXIS_REMAP = 6'h24;
  localparam logic [13:0] RST_FIFO_COUNT = 14'h0000;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // sampling configuration fields
  localparam int CFG_PERF_BIT = 7;
  localparam int CFG_BW_LSB = 4;
  localparam int CFG_RATE_LSB = 0;

  // engine health fields
  localparam int HEALTH_AXIS_FAULT_BIT = 5;
  localparam int HEALTH_SLOW_FAULT_BIT = 6;
  localparam int HEALTH_WAKE_FAULT_BIT = 7;

  // rate codes
  localparam logic [3:0] RATE_FIRST = 4'h1;
  localparam logic [3:0] RATE_50HZ = 4'h7;
  localparam logic [3:0] RATE_LAST = 4'hc;

  // bandwidth codes in continuous filter mode
  localparam logic [2:0] BW_QUAD = 3'h0;
  localparam logic [2:0] BW_DUAL = 3'h1;
  localparam logic [2:0] BW_NORMAL = 3'h2;

  typedef enum logic [1:0] {
    OVS_NORMAL = 2'h0,
    OVS_DUAL = 2'h1,
    OVS_QUAD = 2'h2,
    OVS_NONE = 2'h3
  } acsr_ovs_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_RESP = 2'b10
  } acsr_phase_type;

  typedef struct packed {
    acsr_phase_type phase;
    logic ack;
    logic pop_due;
    logic [7:0] rdat;
    logic [7:0] cfg;
    logic [5:0] remap;
    logic [13:0] count;
  } acsr_state_type;

endpackage

// >>> acsr_cfg_decode.sv
// decoder of the sampling configuration byte into rate, filter and averaging settings
`timescale 1ns/1ps
`default_nettype none

module acsr_cfg_decode (
  input wire logic [7:0] cfg_i,
  output logic [3:0] rate_code_o,
  output logic [11:0] rate_steps_o,
  output logic rate_valid_o,
  output logic perf_mode_o,
  output acsr_pkg::acsr_ovs_type oversample_o,
  output logic [2:0] avg_log2_o,
  output logic bw_valid_o
);

  logic [2:0] bw;
  logic [3:0] rate_idx;

  always_comb begin
    bw = cfg_i[acsr_pkg::CFG_BW_LSB +: 3];
    rate_code_o = cfg_i[acsr_pkg::CFG_RATE_LSB +: 4];
    rate_idx = rate_code_o - acsr_pkg::RATE_FIRST;
    // rate in steps of 25/32 Hz: code 1 is one step, each code doubles
    rate_valid_o = (rate_code_o >= acsr_pkg::RATE_FIRST) &&
                   (rate_code_o <= acsr_pkg::RATE_LAST);
    rate_steps_o = rate_valid_o ? (12'h001 << rate_idx) : 12'h000;
    perf_mode_o = cfg_i[acsr_pkg::CFG_PERF_BIT];
    oversample_o = acsr_pkg::OVS_NONE;
    avg_log2_o = 3'h0;
    bw_valid_o = 1'b1;
    if (perf_mode_o) begin
      case (bw)
        acsr_pkg::BW_QUAD: oversample_o = acsr_pkg::OVS_QUAD;
        acsr_pkg::BW_DUAL: oversample_o = acsr_pkg::OVS_DUAL;
        acsr_pkg::BW_NORMAL: oversample_o = acsr_pkg::OVS_NORMAL;
        default: bw_valid_o = 1'b0;
      endcase
    end else begin
      avg_log2_o = bw;
    end
  end

endmodule

`default_nettype wire

// >>> acsr_byte_src.sv
// behavioural model of the external byte buffer that feeds the read port
`timescale 1ns/1ps
`default_nettype none

module acsr_byte_src (
  input wire logic clk_i,
  input wire logic put_i,
  input wire logic [7:0] put_dat_i,
  input wire logic pop_i,
  output logic push_o,
  output logic [7:0] head_o
);
  logic [7:0] q[$];
  logic [7:0] last = 8'h00;
  initial push_o = 1'b0;
  initial head_o = 8'h00;
  // an empty buffer shows the inverse of the last byte so a stale head never matches
  always @(posedge clk_i) begin
    if (pop_i && q.size() > 0) last = q.pop_front();
    if (put_i) q.push_back(put_dat_i);
    push_o <= put_i;
    head_o <= (q.size() > 0) ? q[0] : ~last;
  end
endmodule

`default_nettype wire

// >>> accel_status_config_regs_tb_top.sv
// self-checking bench of the status and sampling configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

module accel_status_config_regs_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [1:0] motion = 2'h0;
  logic [3:0] estate = 4'h0;
  logic slow_en = 1'b0;
  logic wake_en = 1'b0;
  logic put = 1'b0;
  logic [7:0] put_dat = 8'h00;
  logic [31:0] dat_o;
  logic ack, push, pop, rate_valid, perf, bw_valid, vld;
  logic [7:0] head, r, c;
  logic [3:0] rate_code;
  logic [11:0] steps;
  logic [1:0] ovs;
  logic [2:0] avg;
  logic [5:0] remap;
  logic [31:0] rnd = 32'h00011c1d;
  logic [7:0] exp_q[$];
  int fails = 0;
  int cmp_count = 0;
  int i;

  always #5 clk = ~clk;

  acsr_top DUT (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .FIFO_PUSH_I(push),
    .FIFO_HEAD_I(head), .FIFO_POP_O(pop), .MOTION_CLASS_I(motion), .ENGINE_STATE_I(estate),
    .SLOW_FEAT_EN_I(slow_en), .WAKE_EN_I(wake_en), .RATE_CODE_O(rate_code),
    .RATE_STEPS_O(steps), .RATE_VALID_O(rate_valid), .PERF_MODE_O(perf),
    .OVERSAMPLE_O(ovs), .AVG_LOG2_O(avg), .BW_VALID_O(bw_valid), .AXIS_REMAP_O(remap));

  acsr_byte_src src (.clk_i(clk), .put_i(put), .put_dat_i(put_dat), .pop_i(pop),
    .push_o(push), .head_o(head));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [1:0] exp_ovs(input logic [7:0] v);
    if (!v[7]) return 2'h3;
    case (v[6:4])
      3'h0: return acsr_pkg::OVS_QUAD;
      3'h1: return acsr_pkg::OVS_DUAL;
      3'h2: return acsr_pkg::OVS_NORMAL;
      default: return 2'h3;
    endcase
  endfunction

  function automatic logic axis_bad(input logic [5:0] m);
    return m[1:0] == m[3:2] || m[1:0] == m[5:4] || m[3:2] == m[5:4] ||
      m[1:0] == 2'h3 || m[3:2] == 2'h3 || m[5:4] == 2'h3;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one classic cycle; ack is read right after the edge, before flops update
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    input logic [3:0] s, output logic [7:0] rd);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fails++;
      wrap_up();
    end
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] v;
    wb(1'b0, idx, 8'h00, 4'h1, v);
    `CHK(v, e)
  endtask

  initial begin
    #200us;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(acsr_pkg::IDX_ACCEL_SAMPLING_CFG, 8'ha8);
    rd_chk(acsr_pkg::IDX_FIFO_COUNT_HIGH, 8'h00);
    rd_chk(acsr_pkg::IDX_FIFO_READ_PORT, 8'h00);
    rd_chk(8'h30, 8'h00);
    wb(1'b1, acsr_pkg::IDX_FIFO_COUNT_HIGH, 8'h3f, 4'h1, r);
    rd_chk(acsr_pkg::IDX_FIFO_COUNT_HIGH, 8'h00);
    wb(1'b1, acsr_pkg::IDX_ACCEL_SAMPLING_CFG, 8'h11, 4'h0, r);
    rd_chk(acsr_pkg::IDX_ACCEL_SAMPLING_CFG, 8'ha8);
    for (i = 0; i < 4; i++) begin
      motion <= i[1:0];
      rd_chk(acsr_pkg::IDX_MOTION_CLASS, {6'h0, i[1:0]});
    end
    $display("test reset and status done");
    for (i = 0; i < 256; i++) begin
      c = i[7:0];
      rnd = lfsr(rnd);
      vld = c[3:0] >= 4'h1 && c[3:0] <= 4'hc;
      wb(1'b1, acsr_pkg::IDX_ACCEL_SAMPLING_CFG, c, 4'h1, r);
      rd_chk(acsr_pkg::IDX_ACCEL_SAMPLING_CFG, c);
      `CHK(rate_code, c[3:0])
      `CHK(rate_valid, vld)
      `CHK(steps, vld ? 12'h001 << (c[3:0] - 4'h1) : 12'h000)
      `CHK(perf, c[7])
      `CHK(ovs, exp_ovs(c))
      `CHK(bw_valid, !(c[7] && c[6:4] > 3'h2))
      `CHK(avg, c[7] ? 3'h0 : c[6:4])
      estate <= 4'(i % 5);
      slow_en <= rnd[0];
      wake_en <= rnd[1];
      rd_chk(acsr_pkg::IDX_ENGINE_HEALTH, {rnd[1] && c[3:0] < 4'h8, rnd[0] && c[3:0] < 4'h7,
        2'h0, 4'(i % 5)});
    end
    $display("test sampling config done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(acsr_pkg::IDX_ACCEL_SAMPLING_CFG, 8'ha8);
    rd_chk(acsr_pkg::IDX_ENGINE_HEALTH, {4'h0, estate});
    $display("test mid-run reset done");
    slow_en <= 1'b0;
    wake_en <= 1'b0;
    for (i = 0; i < 20; i++) begin
      rnd = lfsr(rnd);
      c = (i == 0) ? 8'h24 : (i == 1) ? 8'h34 : rnd[7:0];
      wb(1'b1, acsr_pkg::IDX_AXIS_REMAP, c, 4'h1, r);
      rd_chk(acsr_pkg::IDX_ENGINE_HEALTH, {2'h0, axis_bad(c[5:0]), 1'b0, estate});
      `CHK(remap, c[5:0])
    end
    $display("test axis mapping done");
    // 300 bytes crosses into the upper count byte
    for (i = 0; i < 300; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      put <= 1'b1;
      put_dat <= rnd[7:0];
      exp_q.push_back(rnd[7:0]);
    end
    @(posedge clk);
    put <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(acsr_pkg::IDX_FIFO_COUNT_LOW, 8'h2c);
    rd_chk(acsr_pkg::IDX_FIFO_COUNT_HIGH, 8'h01);
    for (i = 0; i < 300; i++) begin
      rd_chk(acsr_pkg::IDX_FIFO_READ_PORT, exp_q.pop_front());
      if (i == 44) begin
        rd_chk(acsr_pkg::IDX_FIFO_COUNT_LOW, 8'hff);
        rd_chk(acsr_pkg::IDX_FIFO_COUNT_HIGH, 8'h00);
      end
    end
    rd_chk(acsr_pkg::IDX_FIFO_COUNT_LOW, 8'h00);
    rd_chk(acsr_pkg::IDX_FIFO_READ_PORT, 8'h00);
    rnd = lfsr(rnd);
    @(posedge clk);
    put <= 1'b1;
    put_dat <= rnd[7:0];
    exp_q.push_back(rnd[7:0]);
    @(posedge clk);
    put <= 1'b0;
    repeat (4) @(posedge clk);
    // three pushes start with the read, so one lands on the edge of the pop
    fork
      rd_chk(acsr_pkg::IDX_FIFO_READ_PORT, exp_q.pop_front());
      begin
        repeat (3) begin
          @(posedge clk);
          rnd = lfsr(rnd);
          put <= 1'b1;
          put_dat <= rnd[7:0];
          exp_q.push_back(rnd[7:0]);
        end
        @(posedge clk);
        put <= 1'b0;
      end
    join
    rd_chk(acsr_pkg::IDX_FIFO_COUNT_LOW, 8'h03);
    for (i = 0; i < 3; i++) begin
      rd_chk(acsr_pkg::IDX_FIFO_READ_PORT, exp_q.pop_front());
    end
    $display("test fifo done");
    wrap_up();
  end
endmodule

`default_nettype wire
